// *** core/tss_shaper.sv ***
// Purpose: frame size, line load, burst and duration shaping of one stream
// Assumes: configuration static during a run; one byte time per clock
// Notes: frames are offered on a valid/ready pair toward the transmit path
`timescale 1ns/1ps
`default_nettype none
`include "tss_map.svh"
module tss_shaper import tss_pkg::*; #(
    parameter int unsigned W      = 16,
    parameter logic [31:0] MS_CYC = `TSS_MS_CYC
) (
    input  wire logic         mclk_i,
    input  wire logic         rst_n_i,
    input  wire logic         gen_start_i,
    input  wire logic         gen_stop_i,
    input  wire logic         test_start_i,
    input  wire logic         auto_start_i,
    input  wire tss_dur_e     dur_mode_i,
    input  wire logic [31:0]  dur_count_i,
    input  wire logic         xmit_burst_i,
    input  wire tss_prof_e    profile_i,
    input  wire logic [W-1:0] enc_load_i,
    input  wire logic [W-1:0] chan_count_i,
    input  wire logic         interframe_gap_unit_i,
    input  wire logic         load_ramp_i,
    input  wire logic [W-1:0] load_start_i,
    input  wire logic [W-1:0] load_end_i,
    input  wire logic [W-1:0] load_step_i,
    input  wire logic [W-1:0] load_dur_i,
    input  wire logic         load_ms_i,
    input  wire tss_ramp_e    load_rmode_i,
    input  wire tss_fsize_e   fsize_mode_i,
    input  wire logic [W-1:0] fsize_start_i,
    input  wire logic [W-1:0] fsize_end_i,
    input  wire logic [W-1:0] fsize_step_i,
    input  wire logic [W-1:0] fsize_dur_i,
    input  wire tss_burst_e   burst_mode_i,
    input  wire logic         burst_count_limit_en_i,
    input  wire logic [31:0]  burst_count_limit_i,
    input  wire logic [W-1:0] burst_start_i,
    input  wire logic [W-1:0] burst_end_i,
    input  wire logic [W-1:0] burst_step_i,
    input  wire tss_ramp_e    burst_rmode_i,
    input  wire logic [W-1:0] burst_gap_i,
    input  wire logic [W-1:0] burst_fsize_i,
    input  wire logic         frm_ready_i,
    output logic              frm_valid_o,
    output logic      [W-1:0] frm_len_o,
    output logic              running_o,
    output logic              done_o,
    output logic      [W-1:0] cur_load_o
);
    tss_state_e          state;
    logic                go;
    logic                run_c;
    logic                live;
    logic                act;
    logic                fire;
    logic                stop_now;
    logic                pace_ok;
    logic [31:0]         frm_cnt;
    logic [31:0]         ms_cnt;
    logic [31:0]         msec_cnt;
    logic [31:0]         sec_cnt;
    logic                ms_tick;
    logic                sec_tick;
    logic                lstep_tick;
    logic [W-1:0]        lstep_cnt;
    logic                load_adv;
    logic [W-1:0]        fstep_cnt;
    logic                fsize_adv;
    logic [W-1:0]        cur_load;
    logic                load_fwd;
    logic [2*W-1:0]      prof_prod;
    logic [W-1:0]        eff_load;
    logic signed [31:0]  credit;
    logic [31:0]         add;
    logic [31:0]         cost;
    logic                in_burst;
    logic [31:0]         bacc;
    logic [31:0]         frame_b;
    logic signed [31:0]  gap_acc;
    logic [31:0]         burst_cnt;
    logic [W-1:0]        cur_blen;
    logic                blen_fwd;
    logic [W-1:0]        blen_eff;
    logic [W-1:0]        rnd_val;
    logic [W:0]          next_load;
    logic [W:0]          next_blen;
    logic [W:0]          next_fsize;

    function automatic logic [W-1:0] step_to(input logic [W-1:0] cur,
                                             input logic [W-1:0] tgt,
                                             input logic [W-1:0] stp);
        if (cur < tgt)
            step_to = (tgt - cur <= stp) ? tgt : W'(cur + stp);
        else
            step_to = (cur - tgt <= stp) ? tgt : W'(cur - stp);
    endfunction : step_to

    // ramp step with end behaviour; msb returns the direction
    function automatic logic [W:0] ramp_adv(input logic [W-1:0] cur,
                                            input logic [W-1:0] st,
                                            input logic [W-1:0] en,
                                            input logic [W-1:0] stp,
                                            input logic         fwd,
                                            input tss_ramp_e    md);
        logic [W-1:0] tgt;
        logic [W-1:0] oth;
        tgt = fwd ? en : st;
        oth = fwd ? st : en;
        ramp_adv = {fwd, step_to(cur, tgt, stp)};
        if (cur == tgt)
        begin
            unique case (md)
                TSS_RAMP_KEEP:   ramp_adv = {fwd, cur};
                TSS_RAMP_REPEAT: ramp_adv = {1'h1, st};
                TSS_RAMP_INVERT: ramp_adv = {~fwd, step_to(cur, oth, stp)};
                default:         ramp_adv = {fwd, cur};
            endcase
        end
    endfunction : ramp_adv

    assign go = gen_start_i | (test_start_i & auto_start_i & (dur_mode_i == TSS_DUR_CONT));
    assign run_c = (state == TSS_ST_RUN);
    assign live = run_c | go;
    assign stop_now = gen_stop_i
                    | ((dur_mode_i == TSS_DUR_SECS) && (sec_cnt >= dur_count_i))
                    | ((dur_mode_i == TSS_DUR_FRMS) && (frm_cnt >= dur_count_i))
                    | (xmit_burst_i && burst_count_limit_en_i
                       && (burst_cnt >= burst_count_limit_i));
    assign act = live & ~stop_now;
    assign pace_ok = xmit_burst_i ? in_burst : ~credit[31];
    assign frm_valid_o = act & pace_ok & ~(xmit_burst_i & (burst_mode_i == TSS_BM_OFF));
    assign fire = frm_valid_o & frm_ready_i;
    assign running_o = run_c;
    assign done_o = (state == TSS_ST_DONE);
    assign cur_load_o = eff_load;

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            state <= TSS_ST_IDLE;
        else
        begin
            unique case (state)
                TSS_ST_IDLE, TSS_ST_DONE: if (go) state <= TSS_ST_RUN;
                TSS_ST_RUN:               if (stop_now) state <= TSS_ST_DONE;
                default:                  state <= TSS_ST_IDLE;
            endcase
        end
    end

    // frame count for the frames unit
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            frm_cnt <= '0;
        else if (!live)
            frm_cnt <= '0;
        else if (fire)
            frm_cnt <= frm_cnt + 32'h1;
    end

    // millisecond and second timebase
    assign ms_tick = run_c && (ms_cnt == MS_CYC - 32'h1);
    assign sec_tick = ms_tick && (msec_cnt == `TSS_MS_PER_S - 32'h1);
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ms_cnt <= '0;
            msec_cnt <= '0;
            sec_cnt <= '0;
        end
        else if (!run_c)
        begin
            ms_cnt <= '0;
            msec_cnt <= '0;
            sec_cnt <= '0;
        end
        else
        begin
            ms_cnt <= ms_tick ? 32'h0 : ms_cnt + 32'h1;
            if (ms_tick)
                msec_cnt <= sec_tick ? 32'h0 : msec_cnt + 32'h1;
            if (sec_tick)
                sec_cnt <= sec_cnt + 32'h1;
        end
    end

    assign lstep_tick = load_ms_i ? ms_tick : sec_tick;
    assign load_adv = lstep_tick
                      && ({1'h0, lstep_cnt} + {{W{1'h0}}, 1'h1} >= {1'h0, load_dur_i});
    assign fsize_adv = sec_tick
                       && ({1'h0, fstep_cnt} + {{W{1'h0}}, 1'h1} >= {1'h0, fsize_dur_i});
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            lstep_cnt <= '0;
            fstep_cnt <= '0;
        end
        else if (!run_c)
        begin
            lstep_cnt <= '0;
            fstep_cnt <= '0;
        end
        else
        begin
            if (lstep_tick)
                lstep_cnt <= load_adv ? '0 : W'(lstep_cnt + 1'h1);
            if (sec_tick)
                fstep_cnt <= fsize_adv ? '0 : W'(fstep_cnt + 1'h1);
        end
    end

    // load ramp walks start to end
    assign next_load = ramp_adv(cur_load, load_start_i, load_end_i, load_step_i,
                                load_fwd, load_rmode_i);
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cur_load <= '0;
            load_fwd <= 1'h1;
        end
        else if (!live)
        begin
            cur_load <= load_start_i;
            load_fwd <= 1'h1;
        end
        else if (load_adv && load_ramp_i)
        begin
            cur_load <= next_load[W-1:0];
            load_fwd <= next_load[W];
        end
    end

    assign prof_prod = {{W{1'h0}}, enc_load_i} * {{W{1'h0}}, chan_count_i};
    always_comb
    begin
        if (profile_i != TSS_PR_DATA)
            eff_load = (|prof_prod[2*W-1:W]) ? {W{1'h1}} : prof_prod[W-1:0];
        else if (load_ramp_i)
            eff_load = cur_load;
        else
            eff_load = load_end_i;
    end

    // gap unit: 12-byte gap is full rate, size lacks preamble
    always_comb
    begin
        add = interframe_gap_unit_i ? `TSS_PCT_FULL : {{(32-W){1'h0}}, eff_load};
        if (interframe_gap_unit_i)
            cost = ({{(32-W){1'h0}}, frm_len_o} + `TSS_PRE_B
                    + {{(32-W){1'h0}}, eff_load}) * `TSS_PCT_FULL;
        else
            cost = ({{(32-W){1'h0}}, frm_len_o} + `TSS_PRE_IFG_B) * `TSS_PCT_FULL;
    end

    // credit pacing; idle credit capped so it cannot hoard
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            credit <= '0;
        else if (!live)
            credit <= '0;
        else if (fire)
            credit <= credit + $signed(add) - $signed(cost);
        else if (credit[31])
            credit <= credit + $signed(add);
    end

    assign next_fsize = ramp_adv(frm_len_o, fsize_start_i, fsize_end_i, fsize_step_i,
                                 1'h1, TSS_RAMP_REPEAT);
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            frm_len_o <= '0;
        else if (xmit_burst_i)
            frm_len_o <= burst_fsize_i;
        else if (!live)
            frm_len_o <= (fsize_mode_i == TSS_FS_RAND) ? rnd_val : fsize_start_i;
        else
        begin
            unique case (fsize_mode_i)
                TSS_FS_CONST: frm_len_o <= fsize_start_i;
                TSS_FS_STEP:  if (fsize_adv) frm_len_o <= next_fsize[W-1:0];
                TSS_FS_RAND:  if (fire) frm_len_o <= rnd_val;
                TSS_FS_INCR:  if (fire)
                                  frm_len_o <= (frm_len_o >= fsize_end_i) ? fsize_start_i
                                               : W'(frm_len_o + 1'h1);
                default:      frm_len_o <= fsize_start_i;
            endcase
        end
    end

    tss_rand #(
        .W (W)
    ) u_rand (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .adv_i   (fire),
        .lo_i    (fsize_start_i),
        .hi_i    (fsize_end_i),
        .val_o   (rnd_val)
    );

    assign blen_eff = (burst_mode_i == TSS_BM_RAMP) ? cur_blen : burst_start_i;
    assign next_blen = ramp_adv(cur_blen, burst_start_i, burst_end_i, burst_step_i,
                                blen_fwd, burst_rmode_i);
    assign frame_b = {{(32-W){1'h0}}, burst_fsize_i} + `TSS_PRE_IFG_B;

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            in_burst <= 1'h1;
            bacc <= '0;
            gap_acc <= '0;
            burst_cnt <= '0;
            cur_blen <= '0;
            blen_fwd <= 1'h1;
        end
        else if (!live || !xmit_burst_i)
        begin
            in_burst <= 1'h1;
            bacc <= '0;
            gap_acc <= '0;
            burst_cnt <= '0;
            cur_blen <= burst_start_i;
            blen_fwd <= 1'h1;
        end
        else if (in_burst)
        begin
            if (fire && (bacc + frame_b >= {{(32-W){1'h0}}, blen_eff}))
            begin
                in_burst <= 1'h0;
                bacc <= '0;
                // gap debt carries, giving an average
                gap_acc <= gap_acc + $signed({{(32-W){1'h0}}, burst_gap_i});
                burst_cnt <= burst_cnt + 32'h1;
                cur_blen <= next_blen[W-1:0];
                blen_fwd <= next_blen[W];
            end
            else if (fire)
                bacc <= bacc + frame_b;
            else if (frm_valid_o)
                gap_acc <= gap_acc - 32'sh1;
        end
        else
        begin
            gap_acc <= gap_acc - 32'sh1;
            if (gap_acc <= 32'sh1)
                in_burst <= 1'h1;
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    logic [W-1:0] len_q;
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            len_q <= '0;
        else
            len_q <= frm_len_o;
    end

    AST_BURST_ONLY: assert property (xmit_burst_i && frm_valid_o |-> in_burst)
        else $error("frame offered outside a burst");
    AST_LOAD_STEP: assert property (run_c && $past(run_c) && load_ramp_i
                                    && profile_i == TSS_PR_DATA && $changed(cur_load)
                                    |-> $past(load_adv))
        else $error("load changed off a step boundary");
    AST_CONST_SIZE: assert property (!xmit_burst_i && fsize_mode_i == TSS_FS_CONST && fire
                                     |-> frm_len_o == fsize_start_i)
        else $error("constant size mismatch");
    AST_RAND_RANGE: assert property (run_c && !xmit_burst_i && fsize_mode_i == TSS_FS_RAND
                                     && frm_valid_o |-> frm_len_o >= fsize_start_i
                                     && frm_len_o <= fsize_end_i)
        else $error("random size out of range");
    AST_INCR_ONE: assert property (run_c && !xmit_burst_i && fsize_mode_i == TSS_FS_INCR
                                   && fire && frm_len_o < fsize_end_i
                                   ##1 run_c |-> frm_len_o == W'(len_q + 1'h1))
        else $error("incremental size did not grow by one");
    AST_BURST_OFF: assert property (xmit_burst_i && burst_mode_i == TSS_BM_OFF
                                    |-> !frm_valid_o)
        else $error("stream sent with burst off");
    AST_BURST_LIMIT: assert property (run_c && xmit_burst_i && burst_count_limit_en_i
                                      && burst_cnt >= burst_count_limit_i
                                      |-> !frm_valid_o ##1 done_o)
        else $error("bursts beyond the limit");
    AST_AUTO_START: assert property (!run_c && test_start_i && auto_start_i
                                     && dur_mode_i == TSS_DUR_CONT && !gen_stop_i
                                     && !xmit_burst_i |-> frm_valid_o ##1 running_o)
        else $error("auto start not in the start cycle");
    AST_FRAME_END: assert property (run_c && dur_mode_i == TSS_DUR_FRMS
                                    && frm_cnt >= dur_count_i |-> !frm_valid_o ##1 done_o)
        else $error("frames beyond the duration");

    COV_BURST_END: cover property (in_burst ##1 !in_burst ##[1:50] in_burst);
    COV_LOAD_STEP: cover property (load_adv && load_ramp_i);
    COV_STEP_SIZE: cover property (fsize_adv && fsize_mode_i == TSS_FS_STEP);
    COV_DONE: cover property (run_c ##1 done_o);
endmodule : tss_shaper
`default_nettype wire

// *** core/tss_map.svh ***
// Purpose: offsets-free constant map for the traffic stream shaper
// Assumes: one byte time per clock for pacing arithmetic
// Notes:
// Notes on behaviour
// - normal mode sends paced frames only; burst mode sends bursts only
// - ramped load starts at start value, steps toward end, holds each step
// - msec option makes load step duration count milliseconds, not seconds
// - at ramp end: hold end, restart from start, or reverse direction
// - gap unit: 12-byte gap is full load; gap met on average
// - constant size mode sends the start size for the whole run
// - stepped size moves start to end by step, each held some seconds
// - continuous duration repeats the stepped sequence without limit
// - seconds or frames duration ends the stream when the count is reached
// - random size mode draws each size uniformly between start and end
// - incremental mode makes each frame one byte longer, start to end
// - frame size excludes preamble and gap
// - burst setting off sends nothing, const fixed, ramp varies length
// - burst count limit stops the stream after that many bursts
// - inter-burst gap is met as an average
// - ramped burst length moves between burst start and end per ramp mode
// - burst length counts each frame as burst frame size plus 20 bytes
// - continuous plus auto start transmits in the test start cycle
// - video and voice load comes from encoding load times channel count
// - duration is continuous, seconds or frames with a count
`ifndef TSS_MAP_SVH
`define TSS_MAP_SVH
`define TSS_CLK_MHZ      32'hfa
`define TSS_MS_US        32'h3e8
`define TSS_MS_CYC       (`TSS_MS_US * `TSS_CLK_MHZ)
`define TSS_MS_PER_S     32'h3e8
`define TSS_PRE_IFG_B    32'h14
`define TSS_PRE_B        32'h8
`define TSS_PCT_FULL     32'h64
`define TSS_LFSR_SEED    16'hace1
`endif

// *** core/tss_pkg.sv ***
// Purpose: shared types of the traffic stream shaper
// Assumes: nothing beyond the constant map
// Notes: configuration codes are software fields, not state
package tss_pkg;
    typedef enum logic [1:0] {TSS_DUR_CONT = 2'h0, TSS_DUR_SECS = 2'h1,
                              TSS_DUR_FRMS = 2'h2} tss_dur_e;
    typedef enum logic [1:0] {TSS_RAMP_KEEP = 2'h0, TSS_RAMP_REPEAT = 2'h1,
                              TSS_RAMP_INVERT = 2'h2} tss_ramp_e;
    typedef enum logic [1:0] {TSS_FS_CONST = 2'h0, TSS_FS_STEP = 2'h1,
                              TSS_FS_RAND = 2'h2, TSS_FS_INCR = 2'h3} tss_fsize_e;
    typedef enum logic [1:0] {TSS_BM_OFF = 2'h0, TSS_BM_CONST = 2'h1,
                              TSS_BM_RAMP = 2'h2} tss_burst_e;
    typedef enum logic [1:0] {TSS_PR_DATA = 2'h0, TSS_PR_VIDEO = 2'h1,
                              TSS_PR_VOICE = 2'h2} tss_prof_e;
    typedef enum logic [2:0] {TSS_ST_IDLE = 3'h1, TSS_ST_RUN = 3'h2,
                              TSS_ST_DONE = 3'h4} tss_state_e;
endpackage : tss_pkg

// *** core/tss_rand.sv ***
// Purpose: uniform random frame size source
// Assumes: lo not above hi
// Notes: scaling by multiply keeps it single cycle, slight bias only
`timescale 1ns/1ps
`default_nettype none
`include "tss_map.svh"
module tss_rand import tss_pkg::*; #(
    parameter int unsigned W = 16
) (
    input  wire logic         mclk_i,
    input  wire logic         rst_n_i,
    input  wire logic         adv_i,
    input  wire logic [W-1:0] lo_i,
    input  wire logic [W-1:0] hi_i,
    output logic      [W-1:0] val_o
);
    logic [15:0]  lfsr;
    logic [W:0]   span;
    logic [W+16:0] prod;

    assign span = {1'h0, hi_i} - {1'h0, lo_i} + {{W{1'h0}}, 1'h1};
    assign prod = {1'h0, span} * {{(W+1){1'h0}}, lfsr};

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            lfsr <= `TSS_LFSR_SEED;
        else if (adv_i)
            lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    end

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            val_o <= '0;
        else
            val_o <= W'(lo_i + W'(prod[W+15:16]));
    end
endmodule : tss_rand
`default_nettype wire

// *** sim/tss_xmit_model.sv ***
// Purpose: transmit path model that takes offered frames
// Assumes: one frame taken per cycle with valid and ready high
// Notes: stall drops ready one cycle in four, like a busy mac
`timescale 1ns/1ps
`default_nettype none
module tss_xmit_model (
    input  wire logic        mclk_i,
    input  wire logic        rst_n_i,
    input  wire logic        stall_i,
    input  wire logic        frm_valid_i,
    input  wire logic [15:0] frm_len_i,
    output logic             frm_ready_o,
    output logic      [31:0] fire_cnt_o,
    output logic      [15:0] last_len_o
);
    logic [1:0] phase;
    assign frm_ready_o = !(stall_i && phase == 2'h0);
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            phase      <= 2'h0;
            fire_cnt_o <= 32'h0;
            last_len_o <= 16'h0;
        end
        else
        begin
            phase <= phase + 2'h1;
            if (frm_valid_i && frm_ready_o)
            begin
                fire_cnt_o <= fire_cnt_o + 32'h1;
                last_len_o <= frm_len_i;
            end
        end
    end
endmodule : tss_xmit_model
`default_nettype wire

// *** sim/test_traffic_stream_shaper.sv ***
// Purpose: self-checking bench of the stream shaper
// Assumes: ms shortened to 2 cycles, so a second is 2000 cycles
// Notes: config changed only while idle
`timescale 1ns/1ps
`default_nettype none
module test_traffic_stream_shaper import tss_pkg::*;;
    logic mclk_i = 1'b0, rst_n_i = 1'b0, stall = 1'b0, rdy, valid, running, done;
    logic gst = 1'b0, gsp = 1'b0, tst = 1'b0, auto = 1'b0, burst = 1'b0, ifgu = 1'b0;
    logic lramp = 1'b0, lms = 1'b0, blim_en = 1'b0;
    tss_dur_e dmode = TSS_DUR_CONT;
    tss_prof_e prof = TSS_PR_DATA;
    tss_ramp_e lrm = TSS_RAMP_KEEP;
    tss_fsize_e fmode = TSS_FS_CONST;
    tss_burst_e bmode = TSS_BM_OFF;
    logic [31:0] dcnt = 32'h0, blim = 32'h0, fires, taken = 32'h0;
    logic [15:0] enc = 16'h0, chan = 16'h0, ls = 16'h0, le = 16'h64, lst = 16'h1, ld = 16'h1;
    logic [15:0] fs = 16'h40, fe = 16'h40, fst = 16'h1, fd = 16'h1, bs = 16'hc8, be = 16'hc8;
    logic [15:0] bst = 16'h1, bgap = 16'h32, bfs = 16'h50, len, cur, last, v;
    int mismatches = 0, n_compared = 0;
    tss_shaper #(.W(16), .MS_CYC(32'h2)) u_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .gen_start_i(gst), .gen_stop_i(gsp), .test_start_i(tst), .auto_start_i(auto),
        .dur_mode_i(dmode), .dur_count_i(dcnt), .xmit_burst_i(burst), .profile_i(prof),
        .enc_load_i(enc), .chan_count_i(chan), .interframe_gap_unit_i(ifgu),
        .load_ramp_i(lramp), .load_start_i(ls), .load_end_i(le), .load_step_i(lst),
        .load_dur_i(ld), .load_ms_i(lms), .load_rmode_i(lrm), .fsize_mode_i(fmode),
        .fsize_start_i(fs), .fsize_end_i(fe), .fsize_step_i(fst), .fsize_dur_i(fd),
        .burst_mode_i(bmode), .burst_count_limit_en_i(blim_en), .burst_count_limit_i(blim),
        .burst_start_i(bs), .burst_end_i(be), .burst_step_i(bst), .burst_rmode_i(lrm),
        .burst_gap_i(bgap), .burst_fsize_i(bfs), .frm_ready_i(rdy), .frm_valid_o(valid),
        .frm_len_o(len), .running_o(running), .done_o(done), .cur_load_o(cur));
    tss_xmit_model u_xmit (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .stall_i(stall),
        .frm_valid_i(valid), .frm_len_i(len), .frm_ready_o(rdy), .fire_cnt_o(fires),
        .last_len_o(last));
    initial
    begin
        forever #2 mclk_i = ~mclk_i;
    end
    task automatic chk(input logic ok, input string msg);
        n_compared++;
        if (ok !== 1'b1)
        begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask : cyc
    // size and random source are registered, so config settles two edges first
    task automatic go();
        cyc(2);
        taken = fires;
        gst = 1'b1;
        cyc(1);
        gst = 1'b0;
    endtask : go
    task automatic halt();
        gsp = 1'b1;
        cyc(1);
        gsp = 1'b0;
        cyc(2);
    endtask : halt
    // waits for a frame not yet seen, bounded; the start cycle frame counts too
    task automatic fire(output logic [15:0] l);
        for (int i = 0; i < 400 && fires === taken; i++) cyc(1);
        chk(fires !== taken, "no frame taken");
        taken = fires;
        l = last;
    endtask : fire
    task automatic t_const();
        time t0;
        dmode = TSS_DUR_FRMS;
        dcnt = 32'h4;
        go();
        chk(running === 1'b1, "start did not enter run state");
        for (int i = 0; i < 4; i++)
        begin
            fire(v);
            if (i == 0)
                t0 = $time;
            chk(v === 16'h40, "constant size wrong");
        end
        chk($time - t0 == 64'd1008, "full load pacing wrong");
        cyc(4);
        chk(done === 1'b1 && valid === 1'b0, "frame count did not end run");
        chk(cur === 16'h64, "constant load wrong");
        ifgu = 1'b1;
        le = 16'hc;
        dcnt = 32'h2;
        go();
        fire(v);
        t0 = $time;
        fire(v);
        chk($time - t0 == 64'd336, "12-byte gap not full load");
        cyc(2);
        ifgu = 1'b0;
        le = 16'h64;
    endtask : t_const
    task automatic t_incr();
        dmode = TSS_DUR_CONT;
        fmode = TSS_FS_INCR;
        fs = 16'h64;
        fe = 16'h66;
        stall = 1'b1;
        go();
        for (int i = 0; i < 5; i++)
        begin
            fire(v);
            chk(v === 16'h64 + 16'(i % 3), "incremental size wrong");
        end
        halt();
        fmode = TSS_FS_RAND;
        fs = 16'h46;
        fe = 16'h5a;
        go();
        for (int i = 0; i < 8; i++)
        begin
            fire(v);
            chk(v >= 16'h46 && v <= 16'h5a, "random size out of range");
        end
        halt();
        stall = 1'b0;
    endtask : t_incr
    task automatic t_burst();
        logic [31:0] k;
        burst = 1'b1;
        k = fires;
        go();
        cyc(200);
        chk(fires === k, "burst off still sent frames");
        halt();
        bmode = TSS_BM_CONST;
        blim_en = 1'b1;
        blim = 32'h3;
        k = fires;
        go();
        for (int i = 0; i < 3000 && done !== 1'b1; i++) cyc(1);
        chk(done === 1'b1, "burst limit did not stop");
        chk(fires - k === 32'h6 && last === 16'h50, "burst frames wrong");
        bmode = TSS_BM_RAMP;
        be = 16'h190;
        bst = 16'h64;
        k = fires;
        go();
        for (int i = 0; i < 3000 && done !== 1'b1; i++) cyc(1);
        chk(done === 1'b1 && fires - k === 32'h9, "ramped burst lengths wrong");
        burst = 1'b0;
    endtask : t_burst
    task automatic t_load();
        lramp = 1'b1;
        lms = 1'b1;
        ls = 16'ha;
        le = 16'h1e;
        lst = 16'ha;
        ld = 16'h8;
        go();
        cyc(5);
        chk(cur === 16'ha, "ramp start load wrong");
        cyc(200);
        chk(cur === 16'h1e, "ramp did not keep end");
        halt();
        lramp = 1'b0;
        prof = TSS_PR_VIDEO;
        enc = 16'h3;
        chan = 16'h5;
        cyc(1);
        chk(cur === 16'hf, "profile load wrong");
        prof = TSS_PR_DATA;
        auto = 1'b1;
        tst = 1'b1;
        #1;
        chk(valid === 1'b1, "auto start late");
        cyc(1);
        tst = 1'b0;
        halt();
    endtask : t_load
    task automatic t_step();
        dmode = TSS_DUR_SECS;
        dcnt = 32'h3;
        fmode = TSS_FS_STEP;
        fs = 16'h40;
        fe = 16'h41;
        go();
        cyc(1000);
        fire(v);
        chk(v === 16'h40, "stepped start size wrong");
        cyc(2000);
        fire(v);
        chk(v === 16'h41, "stepped size did not advance");
        cyc(2000);
        fire(v);
        chk(v === 16'h40, "stepped sequence did not repeat");
        for (int i = 0; i < 1500 && done !== 1'b1; i++) cyc(1);
        chk(done === 1'b1 && valid === 1'b0, "seconds duration did not end run");
    endtask : t_step
    task automatic complete_run();
        if (mismatches == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : complete_run
    initial
    begin
        cyc(4);
        rst_n_i = 1'b1;
        cyc(1);
        t_const();
        t_incr();
        t_burst();
        t_load();
        t_step();
        complete_run();
    end
    initial
    begin
        repeat (20000) @(posedge mclk_i);
        mismatches++;
        complete_run();
    end
endmodule : test_traffic_stream_shaper
`default_nettype wire
